/* File: rtl/shading_pkg.sv */
// constants and types shared by the shading trigger scheduler
package shading_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SECOND_NS = 1_000_000_000;
	localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
	localparam int SECONDS_PER_MIN = 60;
	localparam int LUX_W = 18;
	localparam int LUX_PER_KLUX = 1000;
	localparam logic [5:0] THR_MIN_KLUX = 6'h03;
	localparam logic [5:0] THR_MAX_KLUX = 6'h32;
	localparam logic [5:0] THR_DEF_KLUX = 6'h0A;
	localparam logic [5:0] CYCLE_STEP_MIN = 6'h05;
	localparam logic [3:0] WAIT_MAX_MIN = 4'hA;
	localparam logic [11:0] SUN_CYCLE_SCALE_S = 12'h00A;
	localparam logic [2:0] STEP_SEL_DEF = 3'h3;
	localparam logic [7:0] END_POSITION = 8'h00;
	typedef logic [2:0] delay_sel_t;
	typedef logic [2:0] step_sel_t;
	typedef logic signed [7:0] elev_t;
	typedef enum logic {SHADE_OFF, SHADE_ON} shade_state_t;
endpackage : shading_pkg

/* File: rtl/tick_if.sv */
// second and minute tick pulses from the timebase
`timescale 1ns/1ns
interface tick_if;
	logic secTick;
	logic minTick;
	modport src (output secTick, output minTick);
	modport dst (input secTick, input minTick);
endinterface : tick_if

/* File: rtl/shading_timebase.sv */
// second and minute enable pulses derived from the system clock
`timescale 1ns/1ns
module shading_timebase #(
	parameter int SEC_CYCLES = shading_pkg::SECOND_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// tick pulses
	tick_if.src ticks
);
	import shading_pkg::*;

	logic [31:0] cycCnt_reg, cycCnt_next;
	logic [5:0] secCnt_reg, secCnt_next;
	logic secTick_reg, secTick_next;
	logic minTick_reg, minTick_next;

	always_comb begin
		cycCnt_next = cycCnt_reg + 32'h1;
		secCnt_next = secCnt_reg;
		secTick_next = 1'b0;
		minTick_next = 1'b0;
		if (cycCnt_reg >= 32'(SEC_CYCLES - 1)) begin
			cycCnt_next = 32'h0;
			secTick_next = 1'b1;
			if (secCnt_reg >= 6'(SECONDS_PER_MIN - 1)) begin
				secCnt_next = 6'h0;
				minTick_next = 1'b1;
			end else begin
				secCnt_next = secCnt_reg + 6'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cycCnt_reg <= 32'h0;
			secCnt_reg <= 6'h0;
			secTick_reg <= 1'b0;
			minTick_reg <= 1'b0;
		end else begin
			cycCnt_reg <= cycCnt_next;
			secCnt_reg <= secCnt_next;
			secTick_reg <= secTick_next;
			minTick_reg <= minTick_next;
		end
	end

	assign ticks.secTick = secTick_reg;
	assign ticks.minTick = minTick_reg;
endmodule : shading_timebase

/* File: rtl/shading_trigger_scheduler.sv */
// shading trigger, delays and telegram scheduling
//
// Overview of operation
// - internal threshold in lux is the kilolux setting times 1000
// - hysteresis in lux is the hysteresis setting times 1000
// - brightness above threshold is signalled per facade as one-bit command
// - shading ends only below threshold minus hysteresis
// - shading telegrams optionally repeat every 5 to 60 minutes for settings 1 to 12; 13 to 15 wrap to 1, 6, 11 minutes
// - activation after switch-on delay while brightness still exceeds threshold
// - deactivation after switch-off delay while still below release level
// - commands go out as one bit or as one-byte position
// - slat position follows shading command after 0 to 10 minutes
// - sun position repeats every setting times ten seconds
// - sun position resent on elevation change of selected step
// - slat position repeats every setting minutes
// - slat position resent on elevation change, default step 10 degrees
// - optionally send blind height when shading ends
// - optionally send slat position when shading ends
// - threshold setting accepted from 3 to 50 kilolux, default 10
`timescale 1ns/1ns
module shading_trigger_scheduler #(
	parameter int SEC_CYCLES = shading_pkg::SECOND_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// measurement
	input wire logic [shading_pkg::LUX_W-1:0] brightness,
	input wire shading_pkg::elev_t elevation,
	// threshold configuration
	input wire logic thrExternal,
	input wire logic [shading_pkg::LUX_W-1:0] thrExtLux,
	input wire logic [5:0] thrKlux,
	input wire logic [4:0] hystKlux,
	// timing configuration
	input wire logic [3:0] cycleSel,
	input wire shading_pkg::delay_sel_t onDelaySel,
	input wire shading_pkg::delay_sel_t offDelaySel,
	input wire logic [3:0] slatWaitMin,
	input wire logic [7:0] sunCycle,
	input wire shading_pkg::step_sel_t sunStepSel,
	input wire logic [7:0] slatCycleMin,
	input wire shading_pkg::step_sel_t slatStepSel,
	// output format
	input wire logic formatByte,
	input wire logic [7:0] shadePosition,
	input wire logic [3:0] facadeCount,
	input wire logic sendHeightAtEnd,
	input wire logic sendSlatAtEnd,
	// telegram strobes and values
	output logic shadeSend,
	output logic [7:0] shadeFacade,
	output logic shadeBit,
	output logic [7:0] shadeByte,
	output logic shadingActive,
	output logic slatSend,
	output logic heightSend,
	output logic sunSend,
	output shading_pkg::elev_t sunElevation
);
	import shading_pkg::*;

	tick_if ticks ();

	shading_timebase #(.SEC_CYCLES(SEC_CYCLES)) timebase (
		.clk(clk),
		.rst(rst),
		.ticks(ticks)
	);

	function automatic logic [5:0] delayMin(input delay_sel_t sel);
		case (sel)
			3'h0: delayMin = 6'h00;
			3'h1: delayMin = 6'h01;
			3'h2: delayMin = 6'h03;
			3'h3: delayMin = 6'h05;
			3'h4: delayMin = 6'h0A;
			3'h5: delayMin = 6'h0F;
			3'h6: delayMin = 6'h1E;
			default: delayMin = 6'h3C;
		endcase
	endfunction : delayMin

	function automatic logic [7:0] stepDeg(input step_sel_t sel);
		case (sel)
			3'h0: stepDeg = 8'h01;
			3'h1: stepDeg = 8'h03;
			3'h2: stepDeg = 8'h05;
			3'h3: stepDeg = 8'h0A;
			default: stepDeg = 8'h0F;
		endcase
	endfunction : stepDeg

	function automatic logic [7:0] elevDiff(input elev_t a, input elev_t b);
		logic signed [8:0] d;
		d = 9'(a) - 9'(b);
		elevDiff = d[8] ? 8'(-d) : d[7:0];
	endfunction : elevDiff

	// threshold and release level
	logic [5:0] thrClamped;
	logic [LUX_W-1:0] thrLux, hystLux, relLux;
	logic above, below;

	always_comb begin
		if (thrKlux < THR_MIN_KLUX) begin
			thrClamped = THR_MIN_KLUX;
		end else if (thrKlux > THR_MAX_KLUX) begin
			thrClamped = THR_MAX_KLUX;
		end else begin
			thrClamped = thrKlux;
		end
		thrLux = thrExternal ? thrExtLux
			: LUX_W'(thrClamped * LUX_PER_KLUX);
		hystLux = LUX_W'(hystKlux * LUX_PER_KLUX);
		relLux = (thrLux > hystLux) ? thrLux - hystLux : '0;
		above = brightness > thrLux;
		below = brightness < relLux;
	end

	shade_state_t state_reg, state_next;
	logic [5:0] dly_reg, dly_next;
	logic [5:0] cyc_reg, cyc_next;
	logic waitPend_reg, waitPend_next;
	logic [3:0] wait_reg, wait_next;
	logic [7:0] slatCnt_reg, slatCnt_next;
	logic [11:0] sunCnt_reg, sunCnt_next;
	elev_t lastSlat_reg, lastSlat_next;
	elev_t lastSun_reg, lastSun_next;
	logic shadeSend_reg, shadeSend_next;
	logic [7:0] facade_reg, facade_next;
	logic shadeBit_reg, shadeBit_next;
	logic [7:0] shadeByte_reg, shadeByte_next;
	logic slatSend_reg, slatSend_next;
	logic heightSend_reg, heightSend_next;
	logic sunSend_reg, sunSend_next;
	elev_t sunElev_reg, sunElev_next;
	logic goShade, goEnd, resend, slatDue, sunDue, nowActive;
	logic [3:0] waitLim;

	always_comb begin
		state_next = state_reg;
		dly_next = dly_reg;
		cyc_next = cyc_reg;
		waitPend_next = waitPend_reg;
		wait_next = wait_reg;
		slatCnt_next = slatCnt_reg;
		sunCnt_next = sunCnt_reg;
		lastSlat_next = lastSlat_reg;
		lastSun_next = lastSun_reg;
		facade_next = facade_reg;
		shadeBit_next = shadeBit_reg;
		shadeByte_next = shadeByte_reg;
		sunElev_next = sunElev_reg;
		shadeSend_next = 1'b0;
		slatSend_next = 1'b0;
		heightSend_next = 1'b0;
		sunSend_next = 1'b0;
		goShade = 1'b0;
		goEnd = 1'b0;
		resend = 1'b0;
		slatDue = 1'b0;
		sunDue = 1'b0;
		waitLim = (slatWaitMin > WAIT_MAX_MIN) ? WAIT_MAX_MIN : slatWaitMin;

		// switch-on and switch-off delays
		case (state_reg)
			SHADE_OFF: begin
				if (!above) begin
					dly_next = 6'h0;
				end else if (delayMin(onDelaySel) == 6'h0 || (ticks.minTick
					&& dly_reg + 6'h1 >= delayMin(onDelaySel))) begin
					goShade = 1'b1;
				end else if (ticks.minTick) begin
					dly_next = dly_reg + 6'h1;
				end
			end
			SHADE_ON: begin
				if (!below) begin
					dly_next = 6'h0;
				end else if (delayMin(offDelaySel) == 6'h0 || (ticks.minTick
					&& dly_reg + 6'h1 >= delayMin(offDelaySel))) begin
					goEnd = 1'b1;
				end else if (ticks.minTick) begin
					dly_next = dly_reg + 6'h1;
				end
			end
			default: begin
				state_next = SHADE_OFF;
			end
		endcase
		if (goShade) begin
			state_next = SHADE_ON;
			dly_next = 6'h0;
		end
		if (goEnd) begin
			state_next = SHADE_OFF;
			dly_next = 6'h0;
		end
		nowActive = (state_next == SHADE_ON);

		// cyclic repeat of the shading command
		if (cycleSel != 4'h0 && ticks.minTick) begin
			if (cyc_reg + 6'h1 >= 6'(cycleSel * CYCLE_STEP_MIN)) begin
				resend = 1'b1;
			end else begin
				cyc_next = cyc_reg + 6'h1;
			end
		end
		if (goShade || goEnd || resend) begin
			cyc_next = 6'h0;
			shadeSend_next = 1'b1;
			facade_next = 8'((9'h1 << facadeCount) - 9'h1);
			shadeBit_next = nowActive;
			shadeByte_next = nowActive ? shadePosition : END_POSITION;
		end

		// slat position after the waiting time
		if (goShade) begin
			waitPend_next = 1'b1;
			wait_next = 4'h0;
		end else if (goEnd) begin
			waitPend_next = 1'b0;
		end else if (waitPend_reg) begin
			if (wait_reg >= waitLim) begin
				waitPend_next = 1'b0;
				slatDue = 1'b1;
			end else if (ticks.minTick) begin
				wait_next = wait_reg + 4'h1;
			end
		end

		// slat position while shading is established
		if (state_reg == SHADE_ON && !waitPend_reg && !goEnd) begin
			if (slatCycleMin != 8'h0 && ticks.minTick) begin
				if (slatCnt_reg + 8'h1 >= slatCycleMin) begin
					slatDue = 1'b1;
				end else begin
					slatCnt_next = slatCnt_reg + 8'h1;
				end
			end
			if (elevDiff(elevation, lastSlat_reg) >= stepDeg(slatStepSel)) begin
				slatDue = 1'b1;
			end
		end
		if (goEnd) begin
			heightSend_next = sendHeightAtEnd;
			slatDue = sendSlatAtEnd;
		end
		if (slatDue) begin
			slatSend_next = 1'b1;
			slatCnt_next = 8'h0;
			lastSlat_next = elevation;
		end

		// sun position
		if (sunCycle != 8'h0 && ticks.secTick) begin
			if (sunCnt_reg + 12'h1 >= 12'(sunCycle * SUN_CYCLE_SCALE_S)) begin
				sunDue = 1'b1;
			end else begin
				sunCnt_next = sunCnt_reg + 12'h1;
			end
		end
		if (elevDiff(elevation, lastSun_reg) >= stepDeg(sunStepSel)) begin
			sunDue = 1'b1;
		end
		if (sunDue) begin
			sunSend_next = 1'b1;
			sunCnt_next = 12'h0;
			lastSun_next = elevation;
			sunElev_next = elevation;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= SHADE_OFF;
			dly_reg <= 6'h0;
			cyc_reg <= 6'h0;
			waitPend_reg <= 1'b0;
			wait_reg <= 4'h0;
			slatCnt_reg <= 8'h0;
			sunCnt_reg <= 12'h0;
			lastSlat_reg <= 8'sh00;
			lastSun_reg <= 8'sh00;
			shadeSend_reg <= 1'b0;
			facade_reg <= 8'h00;
			shadeBit_reg <= 1'b0;
			shadeByte_reg <= 8'h00;
			slatSend_reg <= 1'b0;
			heightSend_reg <= 1'b0;
			sunSend_reg <= 1'b0;
			sunElev_reg <= 8'sh00;
		end else begin
			state_reg <= state_next;
			dly_reg <= dly_next;
			cyc_reg <= cyc_next;
			waitPend_reg <= waitPend_next;
			wait_reg <= wait_next;
			slatCnt_reg <= slatCnt_next;
			sunCnt_reg <= sunCnt_next;
			lastSlat_reg <= lastSlat_next;
			lastSun_reg <= lastSun_next;
			shadeSend_reg <= shadeSend_next;
			facade_reg <= facade_next;
			shadeBit_reg <= shadeBit_next;
			shadeByte_reg <= shadeByte_next;
			slatSend_reg <= slatSend_next;
			heightSend_reg <= heightSend_next;
			sunSend_reg <= sunSend_next;
			sunElev_reg <= sunElev_next;
		end
	end

	assign shadeSend = shadeSend_reg;
	assign shadeFacade = facade_reg;
	assign shadeBit = shadeBit_reg;
	assign shadeByte = shadeByte_reg;
	assign shadingActive = (state_reg == SHADE_ON);
	assign slatSend = slatSend_reg;
	assign heightSend = heightSend_reg;
	assign sunSend = sunSend_reg;
	assign sunElevation = sunElev_reg;
endmodule : shading_trigger_scheduler

/* File: verification/actuator_model.sv */
// actuator on the far side: latches the commanded position
`timescale 1ns/1ns
module actuator_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// shading telegram
	input wire logic shadeSend,
	input wire logic shadeBit,
	input wire logic formatByte,
	input wire logic [7:0] shadeByte,
	// position taken up
	output logic [7:0] position
);
	// one-bit long-time command: down is full travel
	always_ff @(posedge clk) begin
		if (rst)
			position <= 8'h00;
		else if (shadeSend)
			position <= formatByte ? shadeByte : {8{shadeBit}};
	end
endmodule : actuator_model

/* File: verification/shading_trigger_scheduler_props.sv */
// assertion checker for the shading trigger scheduler
`timescale 1ns/1ns
module shading_trigger_scheduler_props #(
	parameter int SEC_CYCLES = shading_pkg::SECOND_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// measurement and settings
	input wire logic [shading_pkg::LUX_W-1:0] brightness,
	input wire shading_pkg::elev_t elevation,
	input wire logic thrExternal,
	input wire logic [shading_pkg::LUX_W-1:0] thrExtLux,
	input wire logic [5:0] thrKlux,
	input wire logic [4:0] hystKlux,
	input wire shading_pkg::delay_sel_t onDelaySel,
	input wire shading_pkg::delay_sel_t offDelaySel,
	input wire logic [3:0] slatWaitMin,
	input wire logic [7:0] shadePosition,
	input wire logic [3:0] facadeCount,
	input wire logic sendHeightAtEnd,
	input wire logic sendSlatAtEnd,
	// telegrams
	input wire logic shadeSend,
	input wire logic [7:0] shadeFacade,
	input wire logic shadeBit,
	input wire logic [7:0] shadeByte,
	input wire logic shadingActive,
	input wire logic slatSend,
	input wire logic heightSend,
	input wire logic sunSend,
	input wire shading_pkg::elev_t sunElevation
);
	import shading_pkg::*;
	logic [5:0] klux;
	logic [LUX_W-1:0] thr, hyst, rel;
	logic [7:0] mask;
	logic above, below;
	assign klux = (thrKlux < THR_MIN_KLUX) ? THR_MIN_KLUX :
		((thrKlux > THR_MAX_KLUX) ? THR_MAX_KLUX : thrKlux);
	assign thr = thrExternal ? thrExtLux
		: LUX_W'(klux * LUX_PER_KLUX);
	assign hyst = LUX_W'(hystKlux * LUX_PER_KLUX);
	assign rel = (hyst >= thr) ? '0 : thr - hyst;
	assign above = brightness > thr;
	assign below = brightness < rel;
	assign mask = 8'hFF >> (4'h8 - facadeCount);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence start_s;
		shadeSend && shadeBit;
	endsequence
	// onset only, repeats excluded
	sequence rise_s;
		shadeSend && shadeBit && $rose(shadingActive);
	endsequence
	sequence end_s;
		shadeSend && !shadeBit && $fell(shadingActive);
	endsequence
	AST_FACADE: assert property (shadeSend |->
		shadeFacade == $past(mask))
		else $error("facade mask wrong");
	AST_STATE_SEND: assert property ($changed(shadingActive) |->
		shadeSend && shadeBit == shadingActive)
		else $error("state change without telegram");
	AST_ON_NOW: assert property (onDelaySel == 3'h0 &&
		!shadingActive && above |=> shadingActive)
		else $error("no immediate start");
	AST_NO_START: assert property (!shadingActive && !above
		|=> !shadingActive) else $error("start without exceedance");
	AST_OFF_NOW: assert property (offDelaySel == 3'h0 &&
		shadingActive && below |=> !shadingActive)
		else $error("no immediate end");
	AST_BAND: assert property (shadingActive && !below
		|=> shadingActive) else $error("shading ended inside band");
	AST_BYTE_ON: assert property (start_s |->
		shadeByte == $past(shadePosition)) else $error("start byte wrong");
	AST_END_SENDS: assert property (end_s |->
		shadeByte == END_POSITION
		&& heightSend == $past(sendHeightAtEnd)
		&& slatSend == $past(sendSlatAtEnd))
		else $error("end telegrams wrong");
	AST_SLAT_FOLLOW: assert property (rise_s ##0
		slatWaitMin == 4'h0 |=> slatSend)
		else $error("slat not sent after start");
	AST_SUN_VAL: assert property (sunSend |->
		sunElevation == $past(elevation)) else $error("sun value wrong");
endmodule : shading_trigger_scheduler_props

bind shading_trigger_scheduler shading_trigger_scheduler_props #(
	.SEC_CYCLES(SEC_CYCLES)
) props_u (.clk, .rst, .brightness, .elevation, .thrExternal, .thrExtLux,
	.thrKlux, .hystKlux, .onDelaySel, .offDelaySel, .slatWaitMin,
	.shadePosition, .facadeCount, .sendHeightAtEnd, .sendSlatAtEnd,
	.shadeSend, .shadeFacade, .shadeBit, .shadeByte, .shadingActive,
	.slatSend, .heightSend, .sunSend, .sunElevation);

/* File: verification/tb.sv */
// self-checking bench for the shading trigger scheduler
`timescale 1ns/1ns
module tb;
	import shading_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic thrExternal = 1'b0, formatByte = 1'b1;
	logic sendHeightAtEnd = 1'b1, sendSlatAtEnd = 1'b1;
	logic [LUX_W-1:0] brightness = '0, thrExtLux = '0;
	elev_t elevation = 8'h00;
	logic [5:0] thrKlux = 6'h0A;
	logic [4:0] hystKlux = 5'h02;
	logic [3:0] cycleSel = 4'h0, slatWaitMin = 4'h0, facadeCount = 4'h3;
	delay_sel_t onDelaySel = 3'h0, offDelaySel = 3'h0;
	step_sel_t sunStepSel = 3'h4, slatStepSel = 3'h3;
	logic [7:0] sunCycle = 8'h00, slatCycleMin = 8'h00, shadePosition = 8'hA5;
	logic shadeSend, shadeBit, shadingActive, slatSend, heightSend, sunSend;
	logic [7:0] shadeFacade, shadeByte, position;
	elev_t sunElevation;
	int miscompares = 0, checks = 0, cyc = 0, n;
	shading_trigger_scheduler #(.SEC_CYCLES(10)) dut_u (.clk, .rst,
		.brightness, .elevation, .thrExternal, .thrExtLux, .thrKlux,
		.hystKlux, .cycleSel, .onDelaySel, .offDelaySel, .slatWaitMin,
		.sunCycle, .sunStepSel, .slatCycleMin, .slatStepSel, .formatByte,
		.shadePosition, .facadeCount, .sendHeightAtEnd, .sendSlatAtEnd,
		.shadeSend, .shadeFacade, .shadeBit, .shadeByte, .shadingActive,
		.slatSend, .heightSend, .sunSend, .sunElevation);
	actuator_model act_u (.clk, .rst, .shadeSend, .shadeBit, .formatByte,
		.shadeByte, .position);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task final_report;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	task chk(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task chkn(input int got, input int lo, input int hi);
		checks++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, lo);
		end
	endtask : chkn
	function automatic logic pick(input int s);
		case (s)
			0: return shadeSend;
			1: return slatSend;
			2: return sunSend;
			default: return shadingActive;
		endcase
	endfunction : pick
	// settled look after each edge, bounded
	task wfor(input int s, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (pick(s) !== 1'b1 && n < lim);
	endtask : wfor
	task t_start;
		wfor(3, 5);
		chk(shadingActive, 1'b0);
		@(posedge clk) brightness <= 18'h02710;
		wfor(3, 20);
		chk(shadingActive, 1'b0);
		@(posedge clk) brightness <= 18'h02711;
		wfor(0, 5);
		chkn(n, 1, 1);
		chk(shadeBit, 1'b1);
		chk(shadeByte, 8'hA5);
		chk(shadeFacade, 8'h07);
		wfor(1, 3);
		chkn(n, 1, 1);
		chk(position, 8'hA5);
	endtask : t_start
	task t_band;
		@(posedge clk) brightness <= 18'h01F40;
		wfor(0, 20);
		chk(shadingActive, 1'b1);
		@(posedge clk) brightness <= 18'h01F3F;
		wfor(0, 5);
		chkn(n, 1, 1);
		chk(shadeByte, 8'h00);
		chk(heightSend, 1'b1);
		chk(slatSend, 1'b1);
	endtask : t_band
	task t_delay;
		@(posedge clk) onDelaySel <= 3'h3;
		brightness <= 18'h04E20;
		wfor(0, 1300);
		chk(shadingActive, 1'b0);
		@(posedge clk) brightness <= 18'h00000;
		wfor(0, 700);
		@(posedge clk) brightness <= 18'h04E20;
		wfor(3, 3200);
		chkn(n, 2300, 3100);
		@(posedge clk) brightness <= 18'h00000;
		wfor(0, 5);
		chk(shadeBit, 1'b0);
	endtask : t_delay
	task t_repeat;
		@(posedge clk) cycleSel <= 4'h1;
		onDelaySel <= 3'h0;
		formatByte <= 1'b0;
		brightness <= 18'h04E20;
		wfor(0, 5);
		chkn(n, 1, 1);
		// actuator latches one edge after the strobe
		@(posedge clk);
		#1;
		chk(position, 8'hFF);
		wfor(0, 3100);
		chkn(n, 2400, 3000);
		@(posedge clk) elevation <= 8'h09;
		wfor(1, 20);
		chk(slatSend, 1'b0);
		@(posedge clk) elevation <= 8'h0A;
		wfor(1, 5);
		chk(slatSend, 1'b1);
		@(posedge clk) slatCycleMin <= 8'h01;
		wfor(1, 700);
		wfor(1, 700);
		chkn(n, 600, 600);
		@(posedge clk) cycleSel <= 4'h0;
		slatCycleMin <= 8'h00;
		brightness <= 18'h00000;
		wfor(0, 5);
	endtask : t_repeat
	task t_sun;
		@(posedge clk) sunCycle <= 8'h01;
		wfor(2, 200);
		wfor(2, 200);
		chkn(n, 100, 100);
		chk(sunElevation, 8'h0A);
		@(posedge clk) sunCycle <= 8'h00;
		sunStepSel <= 3'h1;
		@(posedge clk) elevation <= 8'h0C;
		wfor(2, 30);
		chk(sunSend, 1'b0);
		@(posedge clk) elevation <= 8'h0D;
		wfor(2, 5);
		chk(sunElevation, 8'h0D);
	endtask : t_sun
	// external threshold, slat wait, switch-off delay, no height at end
	task t_wait;
		@(posedge clk) slatWaitMin <= 4'h2;
		offDelaySel <= 3'h1;
		thrExternal <= 1'b1;
		thrExtLux <= 18'h00100;
		hystKlux <= 5'h00;
		sendHeightAtEnd <= 1'b0;
		facadeCount <= 4'h8;
		brightness <= 18'h00100;
		wfor(3, 20);
		chk(shadingActive, 1'b0);
		@(posedge clk) brightness <= 18'h00101;
		wfor(0, 5);
		chkn(n, 1, 1);
		chk(shadeFacade, 8'hFF);
		wfor(1, 1300);
		chkn(n, 602, 1201);
		@(posedge clk) brightness <= 18'h00000;
		wfor(0, 700);
		chkn(n, 590, 600);
		chk(shadeBit, 1'b0);
		chk(heightSend, 1'b0);
		chk(slatSend, 1'b1);
	endtask : t_wait
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_start();
		t_band();
		t_delay();
		t_repeat();
		t_sun();
		t_wait();
		final_report();
	end
endmodule : tb
